// file: rtl/write_once_config_fuses.sv
`timescale 1ns/100ps
`default_nettype none
module write_once_config_fuses (
    // clock and power-on reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // table access from the core
    input wire cfg_fuse_pkg::tbl_req_t tbl_req,
    output logic [15:0] tbl_rdata,
    output logic tbl_rvalid,
    // configuration to dependent blocks
    output cfg_fuse_pkg::boot_cfg_t boot_cfg
);

    logic [7:0] fuse;
    logic [7:0] next_fuse;
    logic [15:0] next_rdata;
    logic next_rvalid;
    logic hit;

    // address decode; program-space fetches never arrive on this port
    function automatic logic in_cfg_space(input logic [23:0] a);
        return a >= cfg_fuse_pkg::CFG_SPACE_LO
            && a <= cfg_fuse_pkg::CFG_SPACE_HI;
    endfunction

    assign hit = in_cfg_space(tbl_req.addr)
        && tbl_req.addr == cfg_fuse_pkg::BOOT_SEGMENT_CONFIG_ADDR;

    // programming only pulls bits to 0: a 1 never undoes a 0
    always_comb begin
        next_fuse = fuse;
        if (tbl_req.wr && hit) begin
            // upper byte wdata[15:8] ignored, no bits there
            next_fuse = fuse & (tbl_req.wdata[7:0]
                | ~cfg_fuse_pkg::BOOT_CFG_IMPL_MASK);
        end
    end

    // read path; unimplemented bits and unmapped words read as ones
    always_comb begin
        next_rvalid = tbl_req.rd;
        next_rdata = tbl_rdata;
        if (tbl_req.rd) begin
            if (hit) begin
                next_rdata = {cfg_fuse_pkg::UPPER_BYTE_READ, fuse};
            end else begin
                next_rdata = cfg_fuse_pkg::UNMAPPED_READ;
            end
        end
    end

    // reset stands for the power cycle that re-arms the fuses
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fuse <= cfg_fuse_pkg::BOOT_CFG_RESET;
            tbl_rdata <= cfg_fuse_pkg::TBL_RDATA_RESET;
            tbl_rvalid <= 1'b0;
        end else begin
            fuse <= next_fuse;
            tbl_rdata <= next_rdata;
            tbl_rvalid <= next_rvalid;
        end
    end

    // continuous view of the fields
    assign boot_cfg.boot_segment_size_select =
        fuse[cfg_fuse_pkg::SIZE_SEL_LSB
            +: cfg_fuse_pkg::SIZE_SEL_WIDTH];
    assign boot_cfg.boot_segment_write_protect =
        fuse[cfg_fuse_pkg::WRITE_PROTECT_BIT];

    // checks: one clock, one reset, so both are declared once here
    default clocking chk_cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    // the protect bit never climbs back to one inside a power cycle
    AST_NO_REPROGRAM: assert property (
        !$past(fuse[cfg_fuse_pkg::WRITE_PROTECT_BIT])
        |-> !fuse[cfg_fuse_pkg::WRITE_PROTECT_BIT]
    ) else begin
        $error("programmed bit returned to one");
    end

    // no bit of the byte may rise; only reset re-arms
    AST_NO_BIT_RISES: assert property (
        1'b1
        |-> (~$past(fuse) & fuse) == 8'h00
    ) else begin
        $error("a programmed bit rose again");
    end

    // a zero written to the protect bit programs it
    AST_WRITE_CLEARS: assert property (
        tbl_req.wr && hit && !tbl_req.wdata[cfg_fuse_pkg::WRITE_PROTECT_BIT]
        |=> !fuse[cfg_fuse_pkg::WRITE_PROTECT_BIT]
    ) else begin
        $error("write of zero did not program bit");
    end

    // every implemented bit written as zero reads zero afterwards
    AST_WRITE_PROGRAMS: assert property (
        tbl_req.wr && hit
        |=> (fuse & ~$past(tbl_req.wdata[7:0])
            & cfg_fuse_pkg::BOOT_CFG_IMPL_MASK) == 8'h00
    ) else begin
        $error("zero write left an implemented bit at one");
    end

    // bits with no storage behind them stay at one
    AST_UPPER_IGNORED: assert property (
        tbl_req.wr && hit
        |=> fuse[7:4] == 4'hf
    ) else begin
        $error("upper bits changed");
    end

    // writes that miss the byte leave it alone
    AST_MISS_NO_EFFECT: assert property (
        tbl_req.wr && !hit
        |=> $stable(fuse)
    ) else begin
        $error("write outside map changed fuses");
    end

    // without a write the byte holds
    AST_IDLE_NO_EFFECT: assert property (
        !tbl_req.wr
        |=> $stable(fuse)
    ) else begin
        $error("fuses changed without a write");
    end

    // a read of the base word returns the byte as it stood
    AST_READ_BACK: assert property (
        tbl_req.rd && tbl_req.addr == cfg_fuse_pkg::BOOT_SEGMENT_CONFIG_ADDR
        |=> tbl_rvalid
            && tbl_rdata == {cfg_fuse_pkg::UPPER_BYTE_READ, $past(fuse)}
    ) else begin
        $error("read of config byte wrong");
    end

    // unmapped words read as all ones
    AST_READ_ONES: assert property (
        tbl_req.rd && !hit
        |=> tbl_rdata == cfg_fuse_pkg::UNMAPPED_READ
    ) else begin
        $error("unmapped read not all ones");
    end

    // dependent blocks see what a read returns, unless a write raced it
    AST_OUT_MATCH: assert property (
        tbl_req.rd && hit
        |=> tbl_rdata[3:0] == {boot_cfg.boot_segment_size_select,
            boot_cfg.boot_segment_write_protect} || $past(tbl_req.wr)
    ) else begin
        $error("outputs disagree with readback");
    end

    // each read is answered on the next edge
    AST_RVALID: assert property (
        tbl_req.rd
        |=> tbl_rvalid
    ) else begin
        $error("read not answered");
    end

    // valid is a single pulse per read, never spontaneous
    AST_RVALID_PULSE: assert property (
        !tbl_req.rd
        |=> !tbl_rvalid
    ) else begin
        $error("valid without a read");
    end

    // read data holds between reads
    AST_RDATA_HOLD: assert property (
        !tbl_req.rd
        |=> $stable(tbl_rdata)
    ) else begin
        $error("read data moved without a read");
    end

    // the upper byte of every answer reads as all ones
    AST_UPPER_READ: assert property (
        tbl_rvalid
        |-> tbl_rdata[15:8] == cfg_fuse_pkg::UPPER_BYTE_READ
    ) else begin
        $error("upper byte of answer not all ones");
    end

    // protect bit gets programmed
    COV_PROGRAM: cover property (
        $fell(fuse[cfg_fuse_pkg::WRITE_PROTECT_BIT])
    );

    // a second write tries to undo a programmed bit
    COV_RETRY: cover property (
        !fuse[0] && tbl_req.wr && hit && tbl_req.wdata[0]
    );

    // a base read is answered
    COV_READ: cover property (
        tbl_req.rd && hit ##1 tbl_rvalid
    );

    // a write lands outside the byte
    COV_MISS_WRITE: cover property (
        tbl_req.wr && !hit
    );

    // every implemented bit ends programmed
    COV_ALL_PROGRAMMED: cover property (
        (fuse & cfg_fuse_pkg::BOOT_CFG_IMPL_MASK) == 8'h00
    );
endmodule
`default_nettype wire

// file: rtl/cfg_fuse_pkg.sv
`default_nettype none
package cfg_fuse_pkg;
    // table access address space
    localparam logic [23:0] CFG_SPACE_LO = 24'h800000;
    localparam logic [23:0] CFG_SPACE_HI = 24'hffffff;
    localparam logic [23:0] BOOT_SEGMENT_CONFIG_ADDR = 24'hf80000;
    // field positions inside the low byte
    localparam int SIZE_SEL_LSB = 1;
    localparam int SIZE_SEL_WIDTH = 3;
    localparam int WRITE_PROTECT_BIT = 0;
    // implemented low-byte bits: bit 0 and bits 3..1
    localparam logic [7:0] BOOT_CFG_IMPL_MASK = 8'h0f;
    // unprogrammed state after power up
    localparam logic [7:0] BOOT_CFG_RESET = 8'hff;
    localparam logic [7:0] UPPER_BYTE_READ = 8'hff;
    localparam logic [7:0] LOW_BYTE_WRITE_LOCK_RESET = 8'h00;
    // unmapped words and the read register after reset read as ones
    localparam logic [15:0] UNMAPPED_READ = 16'hffff;
    localparam logic [15:0] TBL_RDATA_RESET = 16'hffff;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [23:0] addr;
        logic [15:0] wdata;
    } tbl_req_t;

    typedef struct packed {
        logic [SIZE_SEL_WIDTH-1:0] boot_segment_size_select;
        logic boot_segment_write_protect;
    } boot_cfg_t;
endpackage
`default_nettype wire

// file: testbench/cfg_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module cfg_core_model (
    // clock in, table request out
    input wire logic sys_clk,
    output cfg_fuse_pkg::tbl_req_t tbl_req
);
    initial tbl_req = '0;
    // one table op, launched and released on falling edges
    task automatic op(input logic w, input logic [23:0] a,
        input logic [15:0] d);
        @(negedge sys_clk);
        tbl_req = {~w, w, a, 8'hff, d[7:0]};
        @(negedge sys_clk);
        tbl_req = '0;
    endtask
endmodule
`default_nettype wire

// file: testbench/write_once_config_fuses_tb.sv
`timescale 1ns/100ps
`default_nettype none
module write_once_config_fuses_tb;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    cfg_fuse_pkg::tbl_req_t tbl_req;
    cfg_fuse_pkg::boot_cfg_t boot_cfg;
    logic [15:0] tbl_rdata;
    logic tbl_rvalid;
    logic [3:0] fuse = 4'hf;
    logic [31:0] lfsr = 32'hdc51;
    logic [23:0] a;
    int n_fail = 0;
    int num_checks = 0;
    always #4 sys_clk = ~sys_clk;
    write_once_config_fuses i_write_once_config_fuses (.sys_clk(sys_clk),
        .arst_n(arst_n), .tbl_req(tbl_req), .tbl_rdata(tbl_rdata),
        .tbl_rvalid(tbl_rvalid), .boot_cfg(boot_cfg));
    cfg_core_model i_cfg_core_model (.sys_clk(sys_clk), .tbl_req(tbl_req));
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // only the base word carries fuses; all else reads as ones
    function automatic logic [15:0] exp_rdata(input logic [23:0] ad,
        input logic [3:0] f);
        return ad == 24'hf80000 ? {12'hfff, f} : 16'hffff;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // read back; fuse byte lives only at the base address
    task automatic rd(input logic [23:0] ad);
        i_cfg_core_model.op(1'b0, ad, 16'h0000);
        chk({15'h0, tbl_rvalid}, 16'h0001);
        chk(tbl_rdata, exp_rdata(ad, fuse));
        chk({12'h0, boot_cfg}, {12'h0, fuse});
    endtask
    // programming can only clear bits, so the model is an and
    task automatic wr(input logic [23:0] ad, input logic [15:0] d);
        i_cfg_core_model.op(1'b1, ad, d);
        chk({15'h0, tbl_rvalid}, 16'h0000);
        if (ad == 24'hf80000) fuse = fuse & d[3:0];
    endtask
    task automatic wrap_up();
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // about 150 cycles of traffic, generous margin
    initial begin
        #20000;
        n_fail++;
        wrap_up();
    end
    initial begin
        for (int t = 0; t < 2; t++) begin
            fuse = 4'hf;
            repeat (4) @(negedge sys_clk);
            arst_n = 1'b1;
            rd(24'hf80000);
            wr(24'hf80000, 16'hfffa);
            wr(24'hf80000, 16'hffff);
            rd(24'hf80000);
            wr(24'hf80002, 16'h0000);
            rd(24'hf80002);
            for (int i = 0; i < 30; i++) begin
                lfsr = lfsr_step(lfsr);
                a = lfsr[2] ? 24'hf80000 : lfsr[27:4];
                if (lfsr[3]) wr(a, lfsr[19:4]);
                else rd(a);
            end
            $display("test %0d done", t);
            @(negedge sys_clk);
            arst_n = 1'b0;
        end
        wrap_up();
    end
endmodule
`default_nettype wire
